// ---- hbf_cpu_model.sv ----
// Processor bus master model issuing single non-pipelined transfers
`timescale 1ns/1ps
module hbf_cpu_model (
  // Bus clock
  output logic             bus_clk,
  // Control
  output logic             cycle_strobe_n,
  output logic             write_flag,
  output logic             memory_or_io_select,
  output logic [7:0]       lane_enable_n,
  // Data and parity
  output logic [63:0]      d_drv,
  output logic [7:0]       p_drv,
  input  wire logic [63:0] bus_d,
  input  wire logic [7:0]  bus_p,
  input  wire logic        transfer_ack_n,
  // Read result
  output logic             rd_done,
  output logic [63:0]      rd_data,
  output logic [7:0]       rd_par
);
  initial begin
    cycle_strobe_n = 1'h1;
    write_flag = 1'h0;
    memory_or_io_select = 1'h1;
    lane_enable_n = 8'hFF;
    d_drv = 64'h0;
    p_drv = 8'h0;
    rd_done = 1'h0;
    rd_data = 64'h0;
    rd_par = 8'h0;
    bus_clk = 1'h0;
    #13;
    forever #200 bus_clk = ~bus_clk;
  end

  task automatic xfer(input logic wr, input logic mio, input logic [7:0] len,
                      input logic [63:0] d, input logic [7:0] p, output int n);
    n = 0;
    @(posedge bus_clk);
    cycle_strobe_n <= 1'h0;
    write_flag <= wr;
    memory_or_io_select <= mio;
    lane_enable_n <= len;
    d_drv <= wr ? d : ~d_drv;
    p_drv <= wr ? p : ~p_drv;
    @(posedge bus_clk);
    cycle_strobe_n <= 1'h1;
    do begin
      @(posedge bus_clk);
      n++;
    end while (transfer_ack_n !== 1'h0);
    rd_data <= bus_d;
    rd_par <= bus_p;
    rd_done <= !wr;
    // Released lines show the inverse
    d_drv <= ~d_drv;
    p_drv <= ~p_drv;
    @(posedge bus_clk);
    rd_done <= 1'h0;
  endtask
endmodule

// ---- hbf_pkg.sv ----
// Constants, types and helpers shared by the host bus queue target
// What this block does
// RULE1: Bus side at 66 MHz, core at 100 MHz, joined by two queues.
// RULE2: Processor opens each transaction with a low pulse on the strobe.
// RULE3: Acknowledge goes active once data is driven or taken.
// RULE4: Data moves on 64 two-way lines with 8 two-way parity lines.
// RULE5: Processor drives memory-or-I/O select high for memory, low for I/O.
// RULE6: Direction flag is 1 for processor writes, 0 for processor reads.
// RULE7: Every control pin ending in the low suffix is active low.
// RULE8: Byte-lane enables are captured and shape the word put in the queue.
// RULE9: Application reads the inbound queue and writes the outbound queue.
// RULE10: Outgoing data carries even parity, one bit per byte lane of the 64-bit word.
// RULE11: Received parity is stored, checked, and a mismatch raises a fault.
// RULE12: Both queues are 64 bits wide and 15 entries deep.
// RULE13: Controller idles until the cycle strobe goes low.
// RULE14: Direction picks the queue; go only if inbound not full or outbound not empty.
// RULE15: Acknowledge stays high, adding wait states, until the queue is ready.
// RULE16: Write data is sampled in the bus clock after the strobe.
// RULE17: A read spends one bus clock letting the queue output settle.
// RULE18: Second read state drives data with same-cycle parity and completes.
// RULE19: Reference application loops the inbound queue into the outbound queue.
// RULE20: Block is a bus target only and takes part in no arbitration.
// RULE21: Processor bus error indications are ignored.
// RULE22: Parity bit n covers data bits 8n to 8n+7.
// RULE23: Acknowledge is low one bus clock per transfer; reset forces idle.
// RULE24: Only single non-pipelined transfers; one finishes before the next starts.
package hbf_pkg;

  localparam int DATA_W = 64;
  localparam int LANES  = 8;
  localparam int LANE_W = 8;
  localparam int QDEPTH = 15;
  localparam int CNT_W  = 4;

  // ****************************************
  // Register map
  // ****************************************
  localparam int               WB_AW      = 8;
  localparam logic [WB_AW-1:0] REG_CTRL   = 8'h00;
  localparam logic [WB_AW-1:0] REG_STATUS = 8'h04;

  localparam int CTRL_LOOP_BIT  = 0;
  localparam int CTRL_CHECK_BIT = 1;
  localparam logic CTRL_LOOP_RST  = 1'h1;
  localparam logic CTRL_CHECK_RST = 1'h1;

  localparam int ST_INCNT_LSB  = 0;
  localparam int ST_OUTCNT_LSB = 8;
  localparam int ST_FAULT_BIT  = 16;
  localparam int ST_MIO_BIT    = 17;
  localparam int ST_STATE_LSB  = 20;

  typedef enum logic [2:0] {
    HBF_IDLE    = 3'h0,
    HBF_CHECK   = 3'h1,
    HBF_RECEIVE = 3'h2,
    HBF_PREPARE = 3'h3,
    HBF_DRIVE   = 3'h4
  } hbf_state_t;

  typedef struct packed {
    logic                         bus_clk;
    logic                         strobe_n;
    logic                         write;
    logic                         mio;
    logic [LANES-1:0]             lane_en_n;
    logic [LANES-1:0]             parity;
    logic [DATA_W-1:0]            data;
  } hbf_pins_t;

  // Even parity, one bit per byte lane
  function automatic logic [LANES-1:0] even_parity(input logic [DATA_W-1:0] d);
    logic [LANES-1:0] p;
    p = '0;
    for (int i = 0; i < LANES; i++) begin
      p[i] = ^d[i*LANE_W +: LANE_W];
    end
    return p;
  endfunction

endpackage

// ---- hbf_queue.sv ----
// Flip-flop queue with full, empty and fill count
`timescale 1ns/1ps
module hbf_queue #(
  parameter int WIDTH = hbf_pkg::DATA_W,
  parameter int DEPTH = hbf_pkg::QDEPTH,
  parameter int CNT_W = hbf_pkg::CNT_W
) (
  // Clock and control
  input wire logic  clk,
  input wire logic  rst,
  input wire logic  ce,
  // Queue port
  hbf_queue_if.queue q
);

  localparam logic [CNT_W-1:0] LAST = CNT_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [CNT_W-1:0] wr_reg;
  logic [CNT_W-1:0] rd_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic             do_push;
  logic             do_pop;

  assign q.full  = (cnt_reg == FULL);
  assign q.empty = (cnt_reg == '0);
  assign q.count = cnt_reg;
  assign q.rdata = mem_reg[rd_reg];
  assign do_push = ce && q.push && !q.full;
  assign do_pop  = ce && q.pop && !q.empty;

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_reg[wr_reg] <= q.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (do_push) begin
        wr_reg <= (wr_reg == LAST) ? '0 : wr_reg + 1'h1;
      end
      if (do_pop) begin
        rd_reg <= (rd_reg == LAST) ? '0 : rd_reg + 1'h1;
      end
      if (do_push && !do_pop) begin
        cnt_reg <= cnt_reg + 1'h1;
      end else if (do_pop && !do_push) begin
        cnt_reg <= cnt_reg - 1'h1;
      end
    end
  end

endmodule

// ---- hbf_queue_if.sv ----
// Connection bundle between the target and one of its queues
`timescale 1ns/1ps
interface hbf_queue_if #(
  parameter int WIDTH = hbf_pkg::DATA_W,
  parameter int CNT_W = hbf_pkg::CNT_W
);
  logic             push;
  logic [WIDTH-1:0] wdata;
  logic             full;
  logic             pop;
  logic [WIDTH-1:0] rdata;
  logic             empty;
  logic [CNT_W-1:0] count;

  modport queue (input push, wdata, pop, output full, rdata, empty, count);
  modport user  (output push, wdata, pop, input full, rdata, empty, count);
endinterface

// ---- hbf_target.sv ----
// Processor bus target with inbound and outbound queues and parity
`timescale 1ns/1ps
module hbf_target #(
  parameter int DATA_W = hbf_pkg::DATA_W,
  parameter int LANES  = hbf_pkg::LANES,
  parameter int QDEPTH = hbf_pkg::QDEPTH
) (
  // Clock, reset, enable
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       ce,
  // Processor bus
  input  wire logic                       bus_clk,
  input  wire logic                       cycle_strobe_n,
  input  wire logic                       write_flag,
  input  wire logic                       memory_or_io_select,
  input  wire logic [LANES-1:0]           lane_enable_n,
  input  wire logic [DATA_W-1:0]          data_in,
  output logic      [DATA_W-1:0]          data_out,
  output logic      [DATA_W-1:0]          data_oe,
  input  wire logic [LANES-1:0]           lane_parity_in,
  output logic      [LANES-1:0]           lane_parity_out,
  output logic      [LANES-1:0]           lane_parity_oe,
  output logic                            transfer_ack_n,
  output logic                            parity_fault,
  // Application, inbound queue side
  output logic      [DATA_W-1:0]          app_rx_data,
  output logic                            app_rx_valid,
  input  wire logic                       app_rx_ready,
  // Application, outbound queue side
  input  wire logic [DATA_W-1:0]          app_tx_data,
  input  wire logic                       app_tx_valid,
  output logic                            app_tx_ready,
  // Wishbone slave
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [hbf_pkg::WB_AW-1:0]  wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  hbf_pkg::hbf_pins_t pin_raw;
  hbf_pkg::hbf_pins_t sync1_reg;
  hbf_pkg::hbf_pins_t pins_reg;
  logic               bus_clk_d_reg;
  logic               bus_rise;

  assign pin_raw.bus_clk   = bus_clk;
  assign pin_raw.strobe_n  = cycle_strobe_n;
  assign pin_raw.write     = write_flag;
  assign pin_raw.mio       = memory_or_io_select;
  assign pin_raw.lane_en_n = lane_enable_n;
  assign pin_raw.parity    = lane_parity_in;
  assign pin_raw.data      = data_in;

  // RULE1 bus clock sampled
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_reg     <= '1;
      pins_reg      <= '1;
      bus_clk_d_reg <= 1'h1;
    end else if (ce) begin
      sync1_reg     <= pin_raw;
      pins_reg      <= sync1_reg;
      bus_clk_d_reg <= pins_reg.bus_clk;
    end
  end

  assign bus_rise = ce && pins_reg.bus_clk && !bus_clk_d_reg;

  // ****************************************
  // Queues
  // ****************************************
  hbf_queue_if #(.WIDTH(DATA_W), .CNT_W(hbf_pkg::CNT_W)) in_q ();
  hbf_queue_if #(.WIDTH(DATA_W), .CNT_W(hbf_pkg::CNT_W)) out_q ();

  // RULE12 two 64x15 queues
  hbf_queue #(.WIDTH(DATA_W), .DEPTH(QDEPTH), .CNT_W(hbf_pkg::CNT_W)) u_inbound_queue (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .q   (in_q.queue)
  );

  hbf_queue #(.WIDTH(DATA_W), .DEPTH(QDEPTH), .CNT_W(hbf_pkg::CNT_W)) u_outbound_queue (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .q   (out_q.queue)
  );

  // ****************************************
  // Bus cycle controller
  // ****************************************
  hbf_pkg::hbf_state_t state_reg;
  logic                dir_reg;
  logic                mio_reg;
  logic                drive_reg;
  logic                ack_n_reg;
  logic                queue_ready;
  logic                take_write;
  logic [DATA_W-1:0]   lane_mask;
  logic [DATA_W-1:0]   masked_data;

  // RULE14 direction picks queue
  assign queue_ready = dir_reg ? !in_q.full : !out_q.empty;
  assign take_write  = bus_rise && (state_reg == hbf_pkg::HBF_CHECK) && dir_reg && !in_q.full;

  // RULE8 lane enables mask data
  always_comb begin
    lane_mask = '0;
    for (int i = 0; i < LANES; i++) begin
      lane_mask[i*hbf_pkg::LANE_W +: hbf_pkg::LANE_W] = {hbf_pkg::LANE_W{!pins_reg.lane_en_n[i]}};
    end
  end

  assign masked_data = pins_reg.data & lane_mask;

  // RULE13 idle until strobe low
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= hbf_pkg::HBF_IDLE;
    end else if (bus_rise) begin
      unique case (state_reg)
        hbf_pkg::HBF_IDLE: begin
          // RULE2 RULE7 active-low strobe opens cycle
          if (!pins_reg.strobe_n) begin
            state_reg <= hbf_pkg::HBF_CHECK;
          end
        end
        hbf_pkg::HBF_CHECK: begin
          // RULE15 hold until queue ready
          if (queue_ready) begin
            state_reg <= dir_reg ? hbf_pkg::HBF_RECEIVE : hbf_pkg::HBF_PREPARE;
          end
        end
        // RULE17 one settle state
        hbf_pkg::HBF_PREPARE: state_reg <= hbf_pkg::HBF_DRIVE;
        // RULE24 single transfer ends
        hbf_pkg::HBF_RECEIVE: state_reg <= hbf_pkg::HBF_IDLE;
        hbf_pkg::HBF_DRIVE:   state_reg <= hbf_pkg::HBF_IDLE;
        default:              state_reg <= hbf_pkg::HBF_IDLE;
      endcase
    end
  end

  // RULE6 direction latched at strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      dir_reg <= 1'h0;
      mio_reg <= 1'h0;
    end else if (bus_rise && (state_reg == hbf_pkg::HBF_IDLE) && !pins_reg.strobe_n) begin
      dir_reg <= pins_reg.write;
      // RULE5 select kept for status only
      mio_reg <= pins_reg.mio;
    end
  end

  // RULE23 ack low one bus clock
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_n_reg <= 1'h1;
      drive_reg <= 1'h0;
    end else if (bus_rise) begin
      ack_n_reg <= !(((state_reg == hbf_pkg::HBF_CHECK) && dir_reg && queue_ready)
                     || (state_reg == hbf_pkg::HBF_PREPARE));
      drive_reg <= (state_reg == hbf_pkg::HBF_PREPARE);
    end
  end

  // ****************************************
  // Read data path
  // ****************************************
  logic [DATA_W-1:0] data_out_reg;
  logic [LANES-1:0]  parity_out_reg;

  // RULE18 data with same-cycle parity
  always_ff @(posedge clk) begin
    if (rst) begin
      data_out_reg   <= '0;
      parity_out_reg <= '0;
    end else if (bus_rise && (state_reg == hbf_pkg::HBF_PREPARE)) begin
      data_out_reg   <= out_q.rdata;
      // RULE10 even parity per lane
      parity_out_reg <= hbf_pkg::even_parity(out_q.rdata);
    end
  end

  // RULE3 ack marks data moved
  assign transfer_ack_n  = ack_n_reg;
  // RULE4 data and parity driven together
  assign data_out        = data_out_reg;
  assign data_oe         = {DATA_W{drive_reg}};
  assign lane_parity_out = parity_out_reg;
  assign lane_parity_oe  = {LANES{drive_reg}};

  // ****************************************
  // Write capture and parity check
  // ****************************************
  logic [DATA_W-1:0] rx_data_reg;
  logic [LANES-1:0]  rx_lanes_n_reg;
  logic [LANES-1:0]  captured_parity_reg;
  logic              check_pending_reg;
  logic              fault_reg;
  logic              parity_bad;
  logic              fault_clear;
  logic              check_en_reg;

  // RULE16 sample after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_data_reg         <= '0;
      rx_lanes_n_reg      <= '1;
      captured_parity_reg <= '0;
      check_pending_reg   <= 1'h0;
    end else if (ce) begin
      check_pending_reg <= take_write;
      if (take_write) begin
        rx_data_reg         <= masked_data;
        rx_lanes_n_reg      <= pins_reg.lane_en_n;
        captured_parity_reg <= pins_reg.parity;
      end
    end
  end

  // RULE22 one parity bit per lane
  assign parity_bad = |((hbf_pkg::even_parity(rx_data_reg) ^ captured_parity_reg)
                        & ~rx_lanes_n_reg);

  // RULE11 mismatch sets sticky fault
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_reg <= 1'h0;
    end else if (ce) begin
      if (check_pending_reg && check_en_reg && parity_bad) begin
        fault_reg <= 1'h1;
      end else if (fault_clear) begin
        fault_reg <= 1'h0;
      end
    end
  end

  assign parity_fault = fault_reg;

  // ****************************************
  // Application slot
  // ****************************************
  logic loop_en_reg;
  logic loop_move;

  assign loop_move = loop_en_reg && !in_q.empty && !out_q.full;

  // RULE9 application drains and fills
  assign in_q.push     = take_write;
  assign in_q.wdata    = masked_data;
  assign in_q.pop      = loop_en_reg ? loop_move : app_rx_ready;
  assign app_rx_data   = in_q.rdata;
  assign app_rx_valid  = !loop_en_reg && !in_q.empty;
  assign app_tx_ready  = !loop_en_reg && !out_q.full && ce;
  // RULE19 loopback between queues
  assign out_q.push    = loop_en_reg ? loop_move : app_tx_valid;
  assign out_q.wdata   = loop_en_reg ? in_q.rdata : app_tx_data;
  assign out_q.pop     = bus_rise && (state_reg == hbf_pkg::HBF_PREPARE);

  // ****************************************
  // Wishbone registers
  // ****************************************
  logic        wb_hit;
  logic        wb_wr;
  logic        wb_ack_reg;
  logic [31:0] wb_dat_reg;
  logic [31:0] status_word;

  assign wb_hit = wb_cyc_i && wb_stb_i;
  assign wb_wr  = wb_hit && wb_we_i && wb_ack_reg;

  assign fault_clear = wb_wr && (wb_adr_i == hbf_pkg::REG_STATUS) && wb_sel_i[2]
                       && wb_dat_i[hbf_pkg::ST_FAULT_BIT];

  always_comb begin
    status_word = '0;
    status_word[hbf_pkg::ST_INCNT_LSB +: hbf_pkg::CNT_W]  = in_q.count;
    status_word[hbf_pkg::ST_OUTCNT_LSB +: hbf_pkg::CNT_W] = out_q.count;
    status_word[hbf_pkg::ST_FAULT_BIT]                   = fault_reg;
    status_word[hbf_pkg::ST_MIO_BIT]                     = mio_reg;
    status_word[hbf_pkg::ST_STATE_LSB +: 3]              = state_reg;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ack_reg <= 1'h0;
      wb_dat_reg <= '0;
    end else if (ce) begin
      wb_ack_reg <= wb_hit && !wb_ack_reg;
      if (wb_hit && !wb_ack_reg) begin
        unique case (wb_adr_i)
          hbf_pkg::REG_CTRL:   wb_dat_reg <= {30'h0, check_en_reg, loop_en_reg};
          hbf_pkg::REG_STATUS: wb_dat_reg <= status_word;
          default:             wb_dat_reg <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      loop_en_reg  <= hbf_pkg::CTRL_LOOP_RST;
      check_en_reg <= hbf_pkg::CTRL_CHECK_RST;
    end else if (ce && wb_wr && (wb_adr_i == hbf_pkg::REG_CTRL) && wb_sel_i[0]) begin
      loop_en_reg  <= wb_dat_i[hbf_pkg::CTRL_LOOP_BIT];
      check_en_reg <= wb_dat_i[hbf_pkg::CTRL_CHECK_BIT];
    end
  end

  assign wb_ack_o = wb_ack_reg;
  assign wb_dat_o = wb_dat_reg;

  // RULE20 target only, no arbitration
  // RULE21 no error inputs exist

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !ce);

  sequence s_prepare_edge;
    (state_reg == hbf_pkg::HBF_PREPARE) && bus_rise;
  endsequence

  sequence s_ack_low_edge;
    !transfer_ack_n && bus_rise;
  endsequence

  ack_one_clock_a: assert property (s_ack_low_edge |=> transfer_ack_n) // RULE23
    else $error("ack held past one bus clock");

  idle_hold_a: assert property ((state_reg == hbf_pkg::HBF_IDLE)
      && !(bus_rise && !pins_reg.strobe_n) |=> (state_reg == hbf_pkg::HBF_IDLE)) // RULE13
    else $error("left idle without strobe");

  wait_full_a: assert property ((state_reg == hbf_pkg::HBF_CHECK) && dir_reg && in_q.full
      && bus_rise |=> transfer_ack_n && (state_reg == hbf_pkg::HBF_CHECK)) // RULE15
    else $error("ack given to write while inbound full");

  push_masked_a: assert property (in_q.push |-> (in_q.wdata & ~lane_mask) == '0
      ##1 check_pending_reg && rx_data_reg == $past(masked_data)) // RULE8
    else $error("disabled lane reached inbound queue");

  drive_parity_a: assert property (data_oe[0] |-> lane_parity_out
      == hbf_pkg::even_parity(data_out) && lane_parity_oe[0] && !transfer_ack_n) // RULE10
    else $error("driven parity wrong or ack missing");

  read_steps_a: assert property (s_prepare_edge |=> (state_reg == hbf_pkg::HBF_DRIVE)
      && data_oe[0] && data_out == $past(out_q.rdata)) // RULE18
    else $error("read did not drive queue head");

  loop_move_a: assert property (loop_en_reg && in_q.pop && !in_q.empty && !out_q.full
      |-> out_q.push && out_q.wdata == in_q.rdata) // RULE19
    else $error("loopback lost a word");

  fault_set_a: assert property (check_pending_reg && check_en_reg && parity_bad
      |=> parity_fault) // RULE11
    else $error("parity mismatch not flagged");

  reset_idle_a: assert property (@(posedge clk) disable iff (1'h0)
      rst |=> (state_reg == hbf_pkg::HBF_IDLE) && transfer_ack_n && !data_oe[0]) // RULE23
    else $error("reset did not idle the bus");

endmodule

// ---- test_hbf_target.sv ----
// Self-checking bench for the host bus queue target
`timescale 1ns/1ps
module test_hbf_target;
  logic        clk, rst, ce, bus_clk, cycle_strobe_n, write_flag, memory_or_io_select;
  logic [7:0]  lane_enable_n, p_drv, lane_parity_in, lane_parity_out, lane_parity_oe, rd_par;
  logic [63:0] d_drv, data_in, data_out, data_oe, rd_data, app_rx_data, app_tx_data, e, v;
  logic        transfer_ack_n, parity_fault, app_rx_valid, app_rx_ready, rd_done;
  logic        app_tx_valid, app_tx_ready, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat_i, wb_dat_o, q, seed;
  int          fail_count, n_tests;
  logic [63:0] exp_d[$], exp_rx[$];

  assign data_in = (data_out & data_oe) | (d_drv & ~data_oe);
  assign lane_parity_in = (lane_parity_out & lane_parity_oe) | (p_drv & ~lane_parity_oe);

  hbf_target hbf_target_inst (.clk(clk), .rst(rst), .ce(ce), .bus_clk(bus_clk),
    .cycle_strobe_n(cycle_strobe_n), .write_flag(write_flag),
    .memory_or_io_select(memory_or_io_select), .lane_enable_n(lane_enable_n),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .lane_parity_in(lane_parity_in), .lane_parity_out(lane_parity_out),
    .lane_parity_oe(lane_parity_oe), .transfer_ack_n(transfer_ack_n),
    .parity_fault(parity_fault), .app_rx_data(app_rx_data), .app_rx_valid(app_rx_valid),
    .app_rx_ready(app_rx_ready), .app_tx_data(app_tx_data), .app_tx_valid(app_tx_valid),
    .app_tx_ready(app_tx_ready), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack));

  hbf_cpu_model hbf_cpu_model_inst (.bus_clk(bus_clk), .cycle_strobe_n(cycle_strobe_n),
    .write_flag(write_flag), .memory_or_io_select(memory_or_io_select),
    .lane_enable_n(lane_enable_n), .d_drv(d_drv), .p_drv(p_drv), .bus_d(data_in),
    .bus_p(lane_parity_in), .transfer_ack_n(transfer_ack_n), .rd_done(rd_done),
    .rd_data(rd_data), .rd_par(rd_par));

  // ****
  // Helpers
  // ****
  function automatic logic [7:0] par(input logic [63:0] d);
    for (int i = 0; i < 8; i++) par[i] = ^d[8*i +: 8];
  endfunction

  function automatic logic [63:0] mask(input logic [7:0] len);
    for (int i = 0; i < 8; i++) mask[8*i +: 8] = {8{~len[i]}};
  endfunction

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic next;
    seed = lfsr(seed);
    v = {v[31:0], seed};
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    @(posedge clk);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= we;
    wb_adr <= a;
    wb_sel <= s;
    wb_dat_i <= d;
    do @(posedge clk); while (wb_ack !== 1'h1);
    q = wb_dat_o;
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
    @(negedge clk);
  endtask

  task automatic bwr(input logic [7:0] len, input logic [7:0] p, input logic mio,
                     input logic slow);
    int n;
    hbf_cpu_model_inst.xfer(1'h1, mio, len, v, p, n);
    if (slow) chk(n > 3, 1'h1);
    else chk(64'(n), 64'h1);
  endtask

  task automatic brd(input logic [63:0] d, input logic slow);
    int n;
    exp_d.push_back(d);
    hbf_cpu_model_inst.xfer(1'h0, 1'h1, 8'h00, 64'h0, 8'h00, n);
    if (slow) chk(n > 4, 1'h1);
    else chk(64'(n), 64'h2);
  endtask

  task automatic pop_rx;
    do @(negedge clk); while (app_rx_valid !== 1'h1);
    chk(app_rx_data, exp_rx.pop_front());
    @(posedge clk);
    app_rx_ready <= 1'h1;
    @(posedge clk);
    app_rx_ready <= 1'h0;
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Read results against oldest note
  always @(posedge bus_clk) begin
    if (rd_done === 1'h1) begin
      e = exp_d.size() ? exp_d.pop_front() : ~rd_data;
      chk(rd_data, e);
      chk(rd_par, par(e));
    end
  end

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    finish_test;
  end

  // ****
  // Scenarios
  // ****
  initial begin
    {rst, ce, app_rx_ready, app_tx_valid, wb_cyc, wb_stb, wb_we} = 7'h60;
    {app_tx_data, wb_adr, wb_sel, wb_dat_i, v} = '0;
    {fail_count, n_tests} = '0;
    seed = 32'h3D53;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    chk({transfer_ack_n, data_oe[0], parity_fault}, 3'h4);
    wb(1'h0, hbf_pkg::REG_CTRL, 4'hF, 32'h0);
    chk(q, 32'h3);
    wb(1'h0, 8'h10, 4'hF, 32'h0);
    chk(q, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      next;
      bwr(i == 5 ? 8'hA5 : 8'h00, par(v), i[0], 1'h0);
      exp_rx.push_back(v & mask(i == 5 ? 8'hA5 : 8'h00));
    end
    wb(1'h0, hbf_pkg::REG_STATUS, 4'hF, 32'h0);
    chk(q[17], 1'h1);
    while (exp_rx.size()) brd(exp_rx.pop_front(), 1'h0);
    $display("test loopback done");
    next;
    bwr(8'h00, par(v) ^ 8'h01, 1'h1, 1'h0);
    chk(parity_fault, 1'h1);
    brd(v, 1'h0);
    wb(1'h1, hbf_pkg::REG_STATUS, 4'h4, 32'h0001_0000);
    chk(parity_fault, 1'h0);
    bwr(8'h01, par(v) ^ 8'h01, 1'h1, 1'h0);
    brd(v & mask(8'h01), 1'h0);
    chk(parity_fault, 1'h0);
    $display("test parity done");
    wb(1'h1, hbf_pkg::REG_CTRL, 4'h1, 32'h2);
    for (int i = 0; i < 15; i++) begin
      next;
      exp_rx.push_back(v);
      bwr(8'h00, par(v), 1'h1, 1'h0);
    end
    wb(1'h0, hbf_pkg::REG_STATUS, 4'hF, 32'h0);
    chk(q[3:0], 4'hF);
    next;
    exp_rx.push_back(v);
    fork
      bwr(8'h00, par(v), 1'h1, 1'h1);
      begin
        repeat (60) @(posedge clk);
        pop_rx;
      end
    join
    repeat (15) pop_rx;
    $display("test inbound full done");
    next;
    fork
      brd(v, 1'h1);
      begin
        repeat (30) @(posedge clk);
        ce <= 1'h0;
        @(negedge clk);
        chk({app_tx_ready, transfer_ack_n}, 2'h1);
        @(posedge clk);
        ce <= 1'h1;
        repeat (30) @(posedge clk);
        app_tx_data <= v;
        app_tx_valid <= 1'h1;
        do @(negedge clk); while (app_tx_ready !== 1'h1);
        @(posedge clk);
        app_tx_valid <= 1'h0;
      end
    join
    wb(1'h1, hbf_pkg::REG_CTRL, 4'h1, 32'h3);
    $display("test outbound empty done");
    finish_test;
  end
endmodule
